//--- logic/serial_peripheral_unit.sv
// data path, buffers and flags of the serial peripheral unit
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
module serial_peripheral_unit (
    // clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 sys_rst_in,
    // register port
    input  wire spu_pkg::reg_req_s    reg_req_in,
    output logic [31:0]               reg_rdata_out,
    // serial link
    input  wire logic                 serial_clock_line_in,
    input  wire logic                 frame_select_n_in,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    // interrupt requests
    output spu_pkg::irq_s             irq_out
);
    import spu_pkg::*;

    typedef struct packed {
        logic [31:0] tx_buf;
        logic [31:0] rx_buf;
        logic [31:0] shift;
        logic [31:0] rdata;
        logic        tx_full;
        logic        sr_empty;
        logic        rx_full;
        logic        overrun;
        logic        par_err;
        logic        ovr_seen;
        logic        perr_seen;
        logic        busy;
        logic [4:0]  bit_cnt;
        logic [6:0]  control;
        logic [2:0]  sclk_sync;
        logic [2:0]  sel_sync;
        logic [1:0]  sdi_sync;
        logic        sdo;
    } state_s;

    state_s cur;
    state_s next_cur;

    function automatic logic [31:0] bit_reverse(input logic [31:0] v);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31-i];
        end
        return r;
    endfunction : bit_reverse

    // parity over the 23 data bits below the parity position
    function automatic logic parity_of(input logic [31:0] v, input logic odd);
        return (^v[PAR_BIT-1:0]) ^ odd;
    endfunction : parity_of

    logic        enabled;
    logic        tx_only;
    logic        par_en;
    logic        par_odd;
    logic        sclk_rise;
    logic        sel_fall;
    logic        sel_rise;
    logic        xfer_end;
    logic        hit_data;
    logic        hit_status;
    logic        hit_control;
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic [31:0] status_word;

    assign enabled     = cur.control[CB_ENABLE];
    assign tx_only     = cur.control[CB_TX_ONLY];
    assign par_en      = cur.control[CB_PAR_EN];
    assign par_odd     = cur.control[CB_PAR_ODD];
    // edges are judged on the second and third stages only
    assign sclk_rise   = cur.sclk_sync[1] & ~cur.sclk_sync[2];
    assign sel_fall    = ~cur.sel_sync[1] & cur.sel_sync[2];
    assign sel_rise    = cur.sel_sync[1] & ~cur.sel_sync[2];
    assign xfer_end    = cur.busy & sclk_rise & (cur.bit_cnt == XFER_LAST);
    assign hit_data    = (reg_req_in.addr == OFS_DATA);
    assign hit_status  = (reg_req_in.addr == OFS_STATUS);
    assign hit_control = (reg_req_in.addr == OFS_CONTROL);
    assign rx_word     = bit_reverse(cur.shift);

    always_comb begin
        tx_word = cur.tx_buf;
        if (par_en) begin
            tx_word[PAR_BIT] = parity_of(cur.tx_buf, par_odd);
        end
        status_word = '0;
        status_word[SB_TX_EMPTY] = ~cur.tx_full;
        status_word[SB_RX_FULL]  = cur.rx_full;
        status_word[SB_OVERRUN]  = cur.overrun;
        status_word[SB_PAR_ERR]  = cur.par_err;
        status_word[SB_BUSY]     = cur.busy;
    end

    always_comb begin
        next_cur = cur;
        next_cur.sclk_sync = {cur.sclk_sync[1:0], serial_clock_line_in};
        next_cur.sel_sync  = {cur.sel_sync[1:0], frame_select_n_in};
        next_cur.sdi_sync  = {cur.sdi_sync[0], serial_data_in};

        // register reads: data one cycle later
        next_cur.rdata = '0;
        if (reg_req_in.rd) begin
            if (hit_data) begin
                next_cur.rdata = cur.rx_buf;
                next_cur.rx_full = 1'b0;
            end else if (hit_status) begin
                next_cur.rdata = status_word;
                if (cur.overrun) begin
                    next_cur.ovr_seen = 1'b1;
                end
                if (cur.par_err) begin
                    next_cur.perr_seen = 1'b1;
                end
            end else if (hit_control) begin
                next_cur.rdata = {25'h0, cur.control};
            end
        end

        // register writes
        if (reg_req_in.wr) begin
            if (hit_data && !cur.tx_full && enabled) begin
                next_cur.tx_buf  = reg_req_in.wdata;
                next_cur.tx_full = 1'b1;
            end
            // a data write with the buffer full falls through untouched
            if (hit_status) begin
                if (!reg_req_in.wdata[SB_OVERRUN] && cur.ovr_seen) begin
                    next_cur.overrun  = 1'b0;
                    next_cur.ovr_seen = 1'b0;
                end
                if (!reg_req_in.wdata[SB_PAR_ERR] && cur.perr_seen) begin
                    next_cur.par_err   = 1'b0;
                    next_cur.perr_seen = 1'b0;
                end
            end
            if (hit_control) begin
                next_cur.control = reg_req_in.wdata[6:0];
            end
        end

        // load only when idle; a transfer starting unloaded sends the bits shifted in by the last frame
        if (cur.tx_full && cur.sr_empty && !cur.busy) begin
            next_cur.shift    = bit_reverse(tx_word);
            next_cur.tx_full  = 1'b0;
            next_cur.sr_empty = 1'b0;
        end

        // serial link: shift on each sampled clock rise while a frame is busy
        if (!enabled) begin
            next_cur.busy = 1'b0;
        end else if (sel_fall) begin
            next_cur.busy    = 1'b1;
            next_cur.bit_cnt = '0;
        end else if (sel_rise) begin
            // frame dropped early: abandon without touching buffers
            next_cur.busy = 1'b0;
        end else if (cur.busy && sclk_rise) begin
            next_cur.shift[31:RX_IN_BIT] =
                {cur.shift[30:RX_IN_BIT], cur.sdi_sync[1]};
            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
        end

        if (xfer_end) begin
            next_cur.busy     = 1'b0;
            next_cur.sr_empty = 1'b1;
            next_cur.shift[31:RX_IN_BIT] =
                {cur.shift[30:RX_IN_BIT], cur.sdi_sync[1]};
            if (!tx_only) begin
                if (cur.overrun) begin
                    next_cur.rx_full = 1'b0;
                end else if (cur.rx_full) begin
                    next_cur.overrun  = 1'b1;
                    next_cur.ovr_seen = 1'b0;
                    next_cur.rx_full  = 1'b1;
                end else begin
                    next_cur.rx_buf  = bit_reverse(next_cur.shift);
                    next_cur.rx_full = 1'b1;
                    if (par_en && (bit_reverse(next_cur.shift)[PAR_BIT] !=
                        parity_of(bit_reverse(next_cur.shift), par_odd))) begin
                        next_cur.par_err   = 1'b1;
                        next_cur.perr_seen = 1'b0;
                    end
                end
            end
        end

        // disabled unit holds no pending transmit data; judged on the new
        // control value so the flag follows a disabling write at once
        if (!next_cur.control[CB_ENABLE]) begin
            next_cur.tx_full = 1'b0;
        end
        next_cur.sdo = next_cur.shift[31];
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cur           <= '0;
            cur.tx_buf    <= DATA_RST;
            cur.rx_buf    <= DATA_RST;
            cur.sr_empty  <= 1'b1;
            cur.control   <= CONTROL_RST;
            cur.sel_sync  <= 3'h7;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata_out   = cur.rdata;
    assign serial_data_out = cur.sdo;
    assign irq_out.tx_irq  = ~cur.tx_full & cur.control[CB_TX_IE];
    assign irq_out.rx_irq  = cur.rx_full & cur.control[CB_RX_IE];
    assign irq_out.err_irq = (cur.overrun | cur.par_err)
                             & cur.control[CB_ERR_IE];
endmodule : serial_peripheral_unit

//--- logic/spu_pkg.sv
// constants, register layout and carrier types of the serial peripheral unit
package spu_pkg;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  OFS_DATA     = 4'h0;
    localparam logic [3:0]  OFS_STATUS   = 4'h4;
    localparam logic [3:0]  OFS_CONTROL  = 4'h8;
    // control bit positions
    localparam int          CB_ENABLE    = 0;
    localparam int          CB_TX_ONLY   = 1;
    localparam int          CB_PAR_EN    = 2;
    localparam int          CB_PAR_ODD   = 3;
    localparam int          CB_TX_IE     = 4;
    localparam int          CB_RX_IE     = 5;
    localparam int          CB_ERR_IE    = 6;
    // status bit positions
    localparam int          SB_TX_EMPTY  = 0;
    localparam int          SB_RX_FULL   = 1;
    localparam int          SB_OVERRUN   = 2;
    localparam int          SB_PAR_ERR   = 3;
    localparam int          SB_BUSY      = 4;
    localparam logic [6:0]  CONTROL_RST  = 7'h00;
    localparam logic [31:0] DATA_RST     = 32'h0000_0000;
    // transfer geometry: 24 bits, shifted in at bit 8
    localparam logic [4:0]  XFER_LAST    = 5'h17;
    localparam int          PAR_BIT      = 23;
    localparam int          RX_IN_BIT    = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    typedef struct packed {
        logic tx_irq;
        logic rx_irq;
        logic err_irq;
    } irq_s;
endpackage : spu_pkg

//--- tb/serial_peripheral_unit_tb.sv
// self-checking bench of the serial peripheral unit
`timescale 1ns/1ns
module serial_peripheral_unit_tb;
    import spu_pkg::*;
    logic        clk;
    logic        rst;
    reg_req_s    req;
    logic [31:0] rdata;
    logic        sclk;
    logic        fsel_n;
    logic        sdi;
    logic        sdo;
    irq_s        irq;
    logic [31:0] rv;
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;

    serial_peripheral_unit serial_peripheral_unit_inst (.core_clk_in(clk), .sys_rst_in(rst),
        .reg_req_in(req), .reg_rdata_out(rdata), .serial_clock_line_in(sclk),
        .frame_select_n_in(fsel_n), .serial_data_in(sdi), .serial_data_out(sdo),
        .irq_out(irq));
    spu_link_master spu_link_master_inst (.serial_clock_line_out(sclk),
        .frame_select_n_out(fsel_n), .serial_data_out(sdi), .serial_data_in(sdo));

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        chk("read", (a == OFS_DATA) ? {8'h0, rdata[23:0]} : rdata, exp);
        @(posedge clk);
    endtask : rd
    task automatic xfer(input logic [23:0] tx, input logic [23:0] exp);
        logic [23:0] got;
        spu_link_master_inst.frame(tx, got);
        repeat (5) @(posedge clk);
        chk("frame", {8'h0, got}, {8'h0, exp});
    endtask : xfer

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            fails++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        req = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_STATUS, 32'h1);
        rd(4'hc, 32'h0);
        wr(OFS_CONTROL, 32'h1);
        wr(OFS_DATA, 32'ha53c96);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_DATA, 32'h123456);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_DATA, 32'hffffff);
        xfer(24'h5a5a5a, 24'ha53c96);
        rd(OFS_STATUS, 32'h3);
        // data read then status read with no gap
        req <= '{addr: OFS_DATA, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.addr <= OFS_STATUS;
        @(negedge clk);
        chk("data", {8'h0, rdata[23:0]}, 32'h5a5a5a);
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        chk("status", rdata, 32'h1);
        @(posedge clk);
        xfer(24'h000f0f, 24'h123456);
        xfer(24'h0ff000, 24'h000f0f);
        rd(OFS_STATUS, 32'h7);
        rd(OFS_DATA, 32'h000f0f);
        rd(OFS_STATUS, 32'h5);
        wr(OFS_STATUS, 32'h0);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_CONTROL, 32'h5);
        wr(OFS_DATA, 32'h1);
        xfer(24'h000001, 24'h800001);
        wr(OFS_CONTROL, 32'h75);
        chk("irq", {29'h0, irq}, 32'h7);
        rd(OFS_STATUS, 32'hb);
        rd(OFS_DATA, 32'h1);
        chk("irq", {29'h0, irq}, 32'h5);
        wr(OFS_STATUS, 32'h0);
        wr(OFS_CONTROL, 32'h10);
        chk("irq", {29'h0, irq}, 32'h4);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_CONTROL, 32'h3);
        wr(OFS_DATA, 32'h654321);
        xfer(24'h111111, 24'h654321);
        rd(OFS_STATUS, 32'h1);
        results();
    end
endmodule : serial_peripheral_unit_tb

//--- tb/spu_asserts.sv
// port checker of the serial peripheral unit
`timescale 1ns/1ns
module spu_asserts
    import spu_pkg::*;
(
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        sys_rst_in,
    // register port and requests
    input wire reg_req_s    reg_req_in,
    input wire logic [31:0] reg_rdata_out,
    input wire irq_s        irq_out
);
    logic [6:0] ctl;
    logic       st_rd;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // shadow control, updated on the same edge as the design's copy
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctl <= CONTROL_RST;
        end else if (reg_req_in.wr && reg_req_in.addr == OFS_CONTROL) begin
            ctl <= reg_req_in.wdata[6:0];
        end
    end
    assign st_rd = reg_req_in.rd && reg_req_in.addr == OFS_STATUS;
    sequence s_data_rd;
        reg_req_in.rd && reg_req_in.addr == OFS_DATA;
    endsequence
    sequence s_stat_rd;
        st_rd;
    endsequence
    rdata_idle_a: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 32'h0)
        else $error("read data not zero outside read");
    tx_dis_a: assert property (!ctl[CB_ENABLE] && ctl[CB_TX_IE] |-> irq_out.tx_irq)
        else $error("no transmit request while disabled");
    tx_mask_a: assert property (!ctl[CB_TX_IE] |-> !irq_out.tx_irq)
        else $error("masked transmit request");
    rx_mask_a: assert property (!ctl[CB_RX_IE] |-> !irq_out.rx_irq)
        else $error("masked receive request");
    err_mask_a: assert property (!ctl[CB_ERR_IE] |-> !irq_out.err_irq)
        else $error("masked error request");
    tx_flag_a: assert property ($past(st_rd && ctl[CB_TX_IE])
        |-> reg_rdata_out[SB_TX_EMPTY] == $past(irq_out.tx_irq))
        else $error("transmit request differs from empty flag");
    rx_flag_a: assert property ($past(st_rd && ctl[CB_RX_IE])
        |-> reg_rdata_out[SB_RX_FULL] == $past(irq_out.rx_irq))
        else $error("receive request differs from full flag");
    err_flag_a: assert property ($past(st_rd && ctl[CB_ERR_IE])
        |-> (reg_rdata_out[2] | reg_rdata_out[3]) == $past(irq_out.err_irq))
        else $error("error request differs from error flags");
    tx_only_a: assert property ($past(st_rd && ctl[CB_TX_ONLY])
        |-> reg_rdata_out[2:1] == 2'b00)
        else $error("receive flags set in transmit only mode");
    rd_clear_a: assert property (s_data_rd ##1 s_stat_rd |=> !reg_rdata_out[SB_RX_FULL])
        else $error("full flag not cleared by data read");
endmodule : spu_asserts
bind serial_peripheral_unit spu_asserts spu_asserts_inst (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out));

//--- tb/spu_link_master.sv
// behavioural link master that runs 24 bit frames
`timescale 1ns/1ns
module spu_link_master (
    // serial link
    output logic      serial_clock_line_out,
    output logic      frame_select_n_out,
    output logic      serial_data_out,
    input  wire logic serial_data_in
);
    initial begin
        serial_clock_line_out = 1'b0;
        frame_select_n_out = 1'b1;
        serial_data_out = 1'b0;
    end
    // bit 0 goes first; clock idles low between frames
    task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
        frame_select_n_out = 1'b0;
        #200;
        for (int i = 0; i < 24; i++) begin
            serial_data_out = tx[i];
            #80;
            rx[i] = serial_data_in;
            serial_clock_line_out = 1'b1;
            #80;
            serial_clock_line_out = 1'b0;
        end
        #100;
        frame_select_n_out = 1'b1;
        // line has no pull, so a released bit must not look stable
        serial_data_out = ~serial_data_out;
    endtask : frame
endmodule : spu_link_master
